// >>> src/sctks_sequencer.sv
// Switched-capacitance touch-key sequencer with Avalon-MM register slave
// Assumes analog switches and comparator outside; comparator output synchronous to clk_sys
//
// Functional notes
// - A start first grounds the integration cap through a switch, then releases it.
// - Then the key cap is charged to reference and dumped onto the integration cap repeatedly, each cycle counted.
// - A crossed threshold ends detection, stores the count and raises the interrupt.
// - Completion shares the interrupt line with the other touch controller; software checks flags.
// - Config A holds enable bit 7, pseudo-random bit 6, reference select bit 5, threshold bit 4, base time 3..0.
// - Each charge and each dump phase lasts base time plus one clock periods.
// - Reference select 0 picks the core supply, 1 the main supply; core supply is advised.
// - Threshold select 1 sets half reference as threshold, 0 the alternative fraction.
// - With pad discharge enabled the pad NMOS is on during zeroing for zero field times 128 clocks.
// - Comparator is sampled every clock and filtered true only when the last N samples are all ones.
// - Repeat field runs 1, 2, 4 or 8 conversions accumulated into the count.
// - The count is cleared on every start and held after completion.
// - Count bits 17..16 read in control/status bits 6..5.
// - The sequencer runs on the fast oscillator clock or a divided version.
`timescale 1ns/100ps

`include "sctks_defines.svh"

module sctks_sequencer #(
    parameter int CNT_W = 18
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Avalon-MM slave
    input  wire logic [15:0]       avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    output logic      [1:0]        avs_response,
    // Analog front end
    input  wire logic              comp_out,
    output logic                   zero_switch_on,
    output logic                   pad_nmos_on,
    output logic                   key_charge_on,
    output logic                   key_dump_on,
    output logic                   ref_voltage_select,
    output logic                   compare_threshold_select,
    output logic                   pseudo_random_enable,
    // Interrupt
    output logic                   irq
);
    import sctks_pkg::*;

    // ----------------------------------------------------------------
    // Operation overview
    // ----------------------------------------------------------------
    // Idle until software writes a start with the enable set
    // Zeroing: integration cap grounded for (4 + zero field) * 128 clocks
    // Pad NMOS helps during the first zero field * 128 clocks of zeroing
    // Charge: key cap tied to the reference for base time + 1 clocks
    // Dump: key cap charge moved onto the integration cap, same length
    // Each finished dump adds one to the cycle count
    // Filtered comparator is judged only at the end of a dump
    // A hit ends one conversion; more repeats go back to zeroing
    // The last hit sets the completion flag and the status bit
    // Clearing the enable mid-run drops straight back to idle
    //
    // Hazards and limits
    // Comparator input is taken as already synchronous to clk_sys
    // A hit in mid-phase is ignored until that dump ends
    // The count is not saturated; software must bound the run time
    // Base time changes in mid-run act on the running phase timer
    // Zero field changes in mid-run act on the running zeroing timer
    // Repeat field is loaded into the repeat counter at start
    // Auto shift divides the count by the number of repeats at the end
    // Pseudo-random mode is passed to the analog side only
    //
    // Register map, one byte register per bus address
    //   config A   : enable, pseudo-random, reference, threshold, base time
    //   config B   : pad discharge, zero field 6..4, filter length 3..0
    //   control    : irq enable, count 17..16, auto shift, repeat, flag, busy
    //   count low  : count 7..0, writes go to an unused shadow
    //   count high : count 15..8, writes go to an unused shadow
    //   irq status : bit 0 sticky completion event, write 1 to clear
    //   irq mask   : bit 0 lets the status bit reach the interrupt
    //
    // Control register write
    //   bit 7 sets the completion interrupt enable
    //   bit 4 sets auto shift, bits 3..2 the repeat field
    //   bit 1 written 0 clears the flag, written 1 leaves it
    //   bit 0 written 1 starts a conversion when enabled and idle
    //
    // Bus timing
    //   First request cycle: waitrequest high, request taken at the edge
    //   Second cycle: waitrequest low, read data and response registered
    //   Writes without byte lane 0 are answered but change nothing
    //   Reads of unmapped addresses answer response 2'b10 and zero data
    //   A write still high after its answer is not taken again; a read still high is taken again every second cycle
    //
    // Interrupt
    //   Level output; the flag path and the status path are ored
    //   Shared with the other touch controller; software reads the flags
    //   A completion in the same cycle as a clear leaves the bit set
    //
    // State encoding
    //   Idle, zeroing, charge and dump use binary codes 0 to 3
    //   Codes 4 to 7 cannot be reached and fall back to idle
    //   Busy reads high in every state but idle
    //
    // Phase timer
    //   One 11-bit up counter shared by all timed states
    //   Cleared on every state change but the drop to idle on disable, compared against the phase length
    //   Eleven bits cover the longest zeroing of 11 * 128 clocks
    //
    // Comparator filter
    //   A 15-bit shift register keeps the recent comparator samples
    //   A hit needs the current sample and the previous N - 1 all high
    //   Lengths 0 and 1 pass the raw comparator
    //
    // Reset
    //   Synchronous and active low; every register returns to zero
    //   Waitrequest still follows read and write during reset
    //
    // Clocking
    //   The whole block runs on clk_sys, the oscillator clock or a divide
    //   Phase lengths are counted in clk_sys periods

    initial begin
        if (CNT_W != 18) begin
            $error("sctks_sequencer: count width must be 18");
        end
        // Longest zeroing must fit the 11-bit phase timer
        if ((`SCTKS_ZERO_BASE + 7) * `SCTKS_ZERO_UNIT > 2047) begin
            $error("sctks_sequencer: zeroing time exceeds timer");
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       cfg_a;
        logic [7:0]       cfg_b;
        logic             irq_en;
        logic             auto_shift;
        logic [1:0]       repeat_count;
        logic             flag;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] wr_count;
        sctks_state_t     st;
        logic [10:0]      tmr;
        logic [3:0]       reps_left;
        logic [14:0]      filt;
        logic             irq_stat;
        logic             irq_mask;
        logic             ack;
        logic [31:0]      rdata;
        logic [1:0]       resp;
    } sctks_regs_t;

    sctks_regs_t r_q;
    sctks_regs_t r_d;

    logic [10:0] phase_len;
    logic [10:0] zero_len;
    logic [10:0] nmos_len;
    logic [3:0]  filt_len;
    logic [14:0] filt_mask;
    logic        cmp_hit;
    logic        wr_en;
    logic        rd_en;
    logic        start_req;
    logic        done;
    logic [15:0] idx;
    logic [7:0]  wbyte;

    // Decoded configuration
    assign phase_len = {7'h00, r_q.cfg_a[3:0]} + 11'h001;
    assign zero_len  = 11'((`SCTKS_ZERO_BASE + r_q.cfg_b[6:4]) * `SCTKS_ZERO_UNIT);
    assign nmos_len  = 11'(r_q.cfg_b[6:4] * `SCTKS_ZERO_UNIT);
    assign filt_len  = r_q.cfg_b[3:0];
    assign idx       = avs_address;
    assign wbyte     = avs_writedata[7:0];
    assign wr_en     = avs_write && r_q.ack == 1'b0 && avs_byteenable[0];
    assign rd_en     = avs_read && r_q.ack == 1'b0;

    // Filter mask: N - 1 ones in the sample history, N = 0 passes raw comparator
    always_comb begin
        filt_mask = 15'h0000;
        for (int i = 0; i < 15; i++) begin
            if (i < int'(filt_len) - 1) begin
                filt_mask[i] = 1'b1;
            end
        end
    end
    assign cmp_hit = comp_out && ((r_q.filt & filt_mask) == filt_mask);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        r_d       = r_q;
        r_d.ack   = 1'b0;
        start_req = 1'b0;
        done      = 1'b0;
        r_d.filt  = {r_q.filt[13:0], comp_out};

        // Register writes
        if (wr_en) begin
            unique case (idx)
                `SCTKS_IDX_CFG_A: r_d.cfg_a = wbyte;
                `SCTKS_IDX_CFG_B: r_d.cfg_b = wbyte;
                `SCTKS_IDX_CTRL_STAT: begin
                    r_d.irq_en       = wbyte[`SCTKS_CS_IEN];
                    r_d.auto_shift   = wbyte[`SCTKS_CS_AUTOSH];
                    r_d.repeat_count = wbyte[`SCTKS_CS_REP_LSB +: 2];
                    if (!wbyte[`SCTKS_CS_FLAG]) begin
                        r_d.flag = 1'b0;
                    end
                    start_req = wbyte[`SCTKS_CS_BUSY];
                end
                `SCTKS_IDX_CNT_LOW:  r_d.wr_count[7:0]  = wbyte;
                `SCTKS_IDX_CNT_HIGH: r_d.wr_count[15:8] = wbyte;
                `SCTKS_IDX_IRQ_STAT: begin
                    if (wbyte[0]) begin
                        r_d.irq_stat = 1'b0;
                    end
                end
                `SCTKS_IDX_IRQ_MASK: r_d.irq_mask = wbyte[0];
                default: ;
            endcase
        end

        // Sequencer
        unique case (r_q.st)
            SCTKS_IDLE: begin
                if (start_req && r_q.cfg_a[`SCTKS_CFGA_EN]) begin
                    r_d.count     = '0;
                    r_d.reps_left = 4'(4'h1 << r_d.repeat_count) - 4'h1;
                    r_d.tmr       = 11'h000;
                    r_d.st        = SCTKS_ZERO;
                end
            end
            // Integration cap grounded
            SCTKS_ZERO: begin
                r_d.tmr = r_q.tmr + 11'h001;
                if (r_q.tmr + 11'h001 >= zero_len) begin
                    r_d.tmr = 11'h000;
                    r_d.st  = SCTKS_CHARGE;
                end
            end
            // Key cap on the reference
            SCTKS_CHARGE: begin
                r_d.tmr = r_q.tmr + 11'h001;
                if (r_q.tmr + 11'h001 >= phase_len) begin
                    r_d.tmr = 11'h000;
                    r_d.st  = SCTKS_DUMP;
                end
            end
            // Key cap onto the integration cap, judged at the end
            SCTKS_DUMP: begin
                r_d.tmr = r_q.tmr + 11'h001;
                if (r_q.tmr + 11'h001 >= phase_len) begin
                    r_d.tmr   = 11'h000;
                    r_d.count = r_q.count + CNT_W'(1);
                    r_d.st    = SCTKS_CHARGE;
                    if (cmp_hit) begin
                        if (r_q.reps_left == 4'h0) begin
                            done     = 1'b1;
                            r_d.st   = SCTKS_IDLE;
                        end else begin
                            r_d.reps_left = r_q.reps_left - 4'h1;
                            r_d.st        = SCTKS_ZERO;
                        end
                    end
                end
            end
            default: r_d.st = SCTKS_IDLE;
        endcase

        // Stop if disabled mid-run
        if (!r_q.cfg_a[`SCTKS_CFGA_EN] && r_q.st != SCTKS_IDLE) begin
            r_d.st = SCTKS_IDLE;
        end

        // Completion events win over software clear
        if (done) begin
            if (r_q.auto_shift) begin
                r_d.count = r_d.count >> r_q.repeat_count;
            end
            r_d.flag     = 1'b1;
            r_d.irq_stat = 1'b1;
        end

        // Read data and bus answer
        if (rd_en || wr_en || avs_write) begin
            r_d.ack  = avs_read || avs_write;
            r_d.resp = 2'b00;
            r_d.rdata = 32'h0000_0000;
            if (rd_en) begin
                unique case (idx)
                    `SCTKS_IDX_CFG_A:    r_d.rdata[7:0] = r_q.cfg_a;
                    `SCTKS_IDX_CFG_B:    r_d.rdata[7:0] = r_q.cfg_b;
                    `SCTKS_IDX_CTRL_STAT: r_d.rdata[7:0] = {r_q.irq_en, r_q.count[17:16],
                                         r_q.auto_shift, r_q.repeat_count, r_q.flag,
                                         r_q.st != SCTKS_IDLE};
                    `SCTKS_IDX_CNT_LOW:  r_d.rdata[7:0] = r_q.count[7:0];
                    `SCTKS_IDX_CNT_HIGH: r_d.rdata[7:0] = r_q.count[15:8];
                    `SCTKS_IDX_IRQ_STAT: r_d.rdata[7:0] = {7'h00, r_q.irq_stat};
                    `SCTKS_IDX_IRQ_MASK: r_d.rdata[7:0] = {7'h00, r_q.irq_mask};
                    default:             r_d.resp = 2'b10;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r_q       <= '0;
            r_q.cfg_a <= `SCTKS_RST_BYTE;
            r_q.cfg_b <= `SCTKS_RST_BYTE;
            r_q.st    <= SCTKS_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign avs_waitrequest          = (avs_read || avs_write) && !r_q.ack;
    assign avs_readdata             = r_q.rdata;
    assign avs_response             = r_q.resp;
    assign zero_switch_on           = r_q.st == SCTKS_ZERO;
    assign pad_nmos_on              = r_q.st == SCTKS_ZERO && r_q.cfg_b[`SCTKS_CFGB_PADDIS]
                                      && r_q.tmr < nmos_len;
    assign key_charge_on            = r_q.st == SCTKS_CHARGE;
    assign key_dump_on              = r_q.st == SCTKS_DUMP;
    assign ref_voltage_select       = r_q.cfg_a[`SCTKS_CFGA_REF];
    assign compare_threshold_select = r_q.cfg_a[`SCTKS_CFGA_VTH];
    assign pseudo_random_enable     = r_q.cfg_a[`SCTKS_CFGA_PSR];
    assign irq = (r_q.irq_en && r_q.flag) || (r_q.irq_stat && r_q.irq_mask);

endmodule // sctks_sequencer

// >>> src/sctks_defines.svh
// Offsets, field positions, reset values and timing counts of the touch sequencer
// Assumes inclusion by bare name from design files
`ifndef SCTKS_DEFINES_SVH
`define SCTKS_DEFINES_SVH

// Register addresses (bus byte address equals the register offset)
`define SCTKS_IDX_CFG_A      16'ha008
`define SCTKS_IDX_CFG_B      16'ha009
`define SCTKS_IDX_CNT_LOW    16'ha00b
`define SCTKS_IDX_CNT_HIGH   16'ha00c
`define SCTKS_IDX_CTRL_STAT  16'ha00a
`define SCTKS_IDX_IRQ_STAT   16'ha00d
`define SCTKS_IDX_IRQ_MASK   16'ha00e

// Configuration A fields
`define SCTKS_CFGA_EN        7
`define SCTKS_CFGA_PSR       6
`define SCTKS_CFGA_REF       5
`define SCTKS_CFGA_VTH       4
// Configuration B fields
`define SCTKS_CFGB_PADDIS    7
`define SCTKS_CFGB_ZERO_LSB  4
// Control and status fields
`define SCTKS_CS_IEN         7
`define SCTKS_CS_AUTOSH      4
`define SCTKS_CS_REP_LSB     2
`define SCTKS_CS_FLAG        1
`define SCTKS_CS_BUSY        0

// Reset values
`define SCTKS_RST_BYTE       8'h00

// Timing: zeroing lasts (4+zero)*128 clocks, pad NMOS zero*128 clocks
`define SCTKS_ZERO_UNIT      128
`define SCTKS_ZERO_BASE      4

`endif

// >>> src/sctks_pkg.sv
// Types of the switched-capacitance touch sequencer
// Assumes sctks_defines.svh for numeric constants
package sctks_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        SCTKS_IDLE   = 3'b000,
        SCTKS_ZERO   = 3'b001,
        SCTKS_CHARGE = 3'b010,
        SCTKS_DUMP   = 3'b011
    } sctks_state_t;

endpackage

// >>> verif/sctks_front_model.sv
// Behavioural key and integration capacitor pair with comparator
// Assumes level phase controls from the sequencer, all on clk_sys
`timescale 1ns/100ps

module sctks_front_model #(
    parameter int STEPS_HALF = 3,
    parameter int STEPS_3Q   = 5
) (
    // Clock
    input  wire logic clk_sys,
    // Phase controls, threshold choice and slow comparator mode
    input  wire logic zero_switch_on,
    input  wire logic key_dump_on,
    input  wire logic compare_threshold_select,
    input  wire logic slow,
    // Comparator
    output logic      comp_out
);
    int         level = 0;
    logic       dump_p = 1'b0;
    logic       hit;
    logic [2:0] dly = 3'h0;
    // Ground on zeroing, one charge step per dump phase
    always @(posedge clk_sys) begin
        dump_p <= key_dump_on;
        if (zero_switch_on === 1'b1) level <= 0;
        else if (key_dump_on === 1'b1 && !dump_p) level <= level + 1;
        dly <= {dly[1:0], hit};
    end
    // Half or three quarters of reference; slow mode lags three clocks
    assign hit = level >= (compare_threshold_select ? STEPS_HALF : STEPS_3Q);
    assign comp_out = slow ? dly[2] : hit;
endmodule // sctks_front_model

// >>> verif/sctks_sequencer_checker.sv
// Concurrent checks on the sequencer ports
// Assumes binding to sctks_sequencer, one clock domain
`timescale 1ns/100ps

module sctks_sequencer_checker (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // Bus
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Front end and interrupt
    input wire logic        zero_switch_on,
    input wire logic        pad_nmos_on,
    input wire logic        key_charge_on,
    input wire logic        key_dump_on,
    input wire logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Request start and its single wait state
    sequence s_req_start; $rose(avs_read || avs_write); endsequence
    sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
    a_one_wait: assert property (s_req_start |-> s_one_wait)
        else $error("waitrequest not exactly one cycle");
    a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_phase_excl: assert property (!(key_charge_on && key_dump_on) && !(zero_switch_on && key_dump_on))
        else $error("phases overlap");
    a_pad_in_zero: assert property (pad_nmos_on |-> zero_switch_on)
        else $error("pad nmos outside zeroing");
    a_zero_first: assert property ($rose(key_charge_on) |-> $past(zero_switch_on) || $past(key_dump_on))
        else $error("charge without zeroing or dump before");
    a_dump_after: assert property ($rose(key_dump_on) |-> $past(key_charge_on))
        else $error("dump not after charge");
    a_zero_min: assert property ($rose(zero_switch_on) |-> zero_switch_on[*8])
        else $error("zeroing too short");
    a_irq_idle: assert property ($rose(irq) |-> ##[0:1] !(zero_switch_on || key_charge_on || key_dump_on))
        else $error("interrupt while sequencing");
endmodule // sctks_sequencer_checker

// >>> verif/switched_cap_touch_sequencer_tb.sv
// Self-checking bench for the touch sequencer
// Assumes front model and checker compiled first
`timescale 1ns/100ps
`include "sctks_defines.svh"

module switched_cap_touch_sequencer_tb;
    logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, comp_out, slow, irq;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable, ph;
    logic [1:0]  avs_response;
    logic        zero_switch_on, pad_nmos_on, key_charge_on, key_dump_on;
    logic        ref_voltage_select, compare_threshold_select, pseudo_random_enable;
    int          err_total, n_checks, run[4], len[4];
    // Design and far side
    sctks_sequencer uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .comp_out(comp_out), .zero_switch_on(zero_switch_on), .pad_nmos_on(pad_nmos_on),
        .key_charge_on(key_charge_on), .key_dump_on(key_dump_on), .ref_voltage_select(ref_voltage_select),
        .compare_threshold_select(compare_threshold_select), .pseudo_random_enable(pseudo_random_enable),
        .irq(irq));
    sctks_front_model fe (.clk_sys(clk_sys), .zero_switch_on(zero_switch_on), .key_dump_on(key_dump_on),
        .compare_threshold_select(compare_threshold_select), .slow(slow), .comp_out(comp_out));
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Last completed length of each phase: charge, dump, zero, pad
    assign ph = {pad_nmos_on, zero_switch_on, key_dump_on, key_charge_on};
    always @(posedge clk_sys) begin
        for (int k = 0; k < 4; k++) begin
            if (ph[k] === 1'b1) run[k] <= run[k] + 1;
            else begin
                if (run[k] != 0) len[k] <= run[k];
                run[k] <= 0;
            end
        end
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon transfer, held until waitrequest samples low
    task bus(input logic wr, input logic [15:0] i, input logic [7:0] d, input logic [3:0] be,
             output logic [7:0] r, output logic [1:0] s);
        int n;
        avs_address <= i;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin err_total++; tally_and_finish; end
        r = avs_readdata[7:0];
        s = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task wr(input logic [15:0] i, input logic [7:0] d);
        logic [7:0] r; logic [1:0] s;
        bus(1'b1, i, d, 4'h1, r, s);
    endtask
    task rd_chk(input logic [15:0] i, input logic [7:0] e);
        logic [7:0] r; logic [1:0] s;
        bus(1'b0, i, 8'h00, 4'hf, r, s);
        check({24'h0, r}, {24'h0, e});
    endtask
    // Reset values, read/write fields, ignored lane, unmapped read
    task t_regs;
        logic [7:0] r; logic [1:0] s;
        rd_chk(`SCTKS_IDX_CFG_A, 8'h00);
        rd_chk(`SCTKS_IDX_CFG_B, 8'h00);
        rd_chk(`SCTKS_IDX_CTRL_STAT, 8'h00);
        bus(1'b0, 16'ha0f0, 8'h00, 4'hf, r, s);
        check({r, 6'h0, s}, {8'h00, 6'h0, 2'b10});
        wr(`SCTKS_IDX_CFG_A, 8'h7a);
        bus(1'b1, `SCTKS_IDX_CFG_A, 8'h05, 4'h0, r, s);
        rd_chk(`SCTKS_IDX_CFG_A, 8'h7a);
        check({ref_voltage_select, compare_threshold_select, pseudo_random_enable}, 3'b111);
        wr(`SCTKS_IDX_CFG_A, 8'h05);
        check({ref_voltage_select, compare_threshold_select, pseudo_random_enable}, 3'b000);
    endtask
    // Start, wait for idle, judge count, fields, phase lengths and interrupt
    task run_conv(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] cs, input logic [17:0] cnt,
                  input logic ei);
        int n; logic [7:0] r; logic [1:0] s;
        wr(`SCTKS_IDX_CFG_B, cb);
        wr(`SCTKS_IDX_CFG_A, ca);
        len = '{0, 0, 0, 0};
        wr(`SCTKS_IDX_CTRL_STAT, cs | 8'h01);
        bus(1'b0, `SCTKS_IDX_CTRL_STAT, 8'h00, 4'hf, r, s);
        check({31'h0, r[0]}, 32'h1);
        n = 0;
        do begin bus(1'b0, `SCTKS_IDX_CTRL_STAT, 8'h00, 4'hf, r, s); n++; end while (r[0] !== 1'b0 && n < 4000);
        if (n >= 4000) begin err_total++; tally_and_finish; end
        rd_chk(`SCTKS_IDX_CNT_LOW, cnt[7:0]);
        rd_chk(`SCTKS_IDX_CNT_HIGH, cnt[15:8]);
        rd_chk(`SCTKS_IDX_CTRL_STAT, {cs[7], cnt[17:16], cs[4:2], 2'b10});
        check(len[0], 32'(ca[3:0]) + 1);
        check(len[1], 32'(ca[3:0]) + 1);
        check(len[2], (4 + 32'(cb[6:4])) * 128);
        check(len[3], cb[7] ? 32'(cb[6:4]) * 128 : 0);
        check({31'h0, irq}, {31'h0, ei});
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 16'h0;
        avs_writedata = 32'h0; avs_byteenable = 4'h0; slow = 1'b0; err_total = 0; n_checks = 0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs;
        run_conv(8'h97, 8'h12, 8'h80, 18'd3, 1'b1);
        wr(`SCTKS_IDX_CTRL_STAT, 8'h80);
        check({31'h0, irq}, 32'h0);
        wr(`SCTKS_IDX_IRQ_STAT, 8'h01);
        run_conv(8'h83, 8'h91, 8'h04, 18'd10, 1'b0);
        wr(`SCTKS_IDX_IRQ_MASK, 8'h01);
        check({31'h0, irq}, 32'h1);
        wr(`SCTKS_IDX_IRQ_STAT, 8'h01);
        rd_chk(`SCTKS_IDX_IRQ_STAT, 8'h00);
        check({31'h0, irq}, 32'h0);
        run_conv(8'h97, 8'h02, 8'h18, 18'd3, 1'b1);
        slow <= 1'b1;
        run_conv(8'h87, 8'h0f, 8'h8c, 18'd48, 1'b1);
        tally_and_finish;
    end
endmodule // switched_cap_touch_sequencer_tb

bind sctks_sequencer sctks_sequencer_checker chk (.clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .zero_switch_on(zero_switch_on), .pad_nmos_on(pad_nmos_on), .key_charge_on(key_charge_on),
    .key_dump_on(key_dump_on), .irq(irq));
